/* File: inc/xdp_regs.vh */
// register offsets, field positions, reset values and timing counts for the data-memory access block
// assumes a 20 MHz core clock
`ifndef XDP_REGS_VH
`define XDP_REGS_VH
// ============================================================
// special function register addresses
`define XDP_AUX1_ADDR 8'hA2
`define XDP_AUX0_ADDR 8'h8E
`define XDP_PTR0_LO_ADDR 8'h82
`define XDP_PTR0_HI_ADDR 8'h83
// ============================================================
// aux_control_one fields
`define XDP_A1_PSEL 0
`define XDP_A1_ZERO 2
`define XDP_A1_UFLAG 3
`define XDP_A1_BOOT 5
// ============================================================
// aux_control_zero fields
`define XDP_A0_EXTSEL 1
`define XDP_A0_XRS_LO 2
`define XDP_A0_XRS_HI 3
`define XDP_A0_STRETCH 5
// ============================================================
// reset values and map
`define XDP_XRS_RESET 2'h0
`define XDP_BOOT_BASE 16'hF800
`define XDP_EXPANDED_RAM_TOP 10'h3FF
`define XDP_EXPANDED_RAM_DEPTH 1024
`define XDP_LOWER_TOP 8'h7F
// ============================================================
// strobe timing in clock periods
`define XDP_STROBE_SHORT 5'h06
`define XDP_STROBE_LONG 5'h1E
`endif

/* File: rtl/xdp_expanded_ram.v */
// on-chip expanded_ram store, 1024 bytes, one access per clock
// assumes the controller decodes hits and drives the write enable
`timescale 1ns/100ps
`include "xdp_regs.vh"
module xdp_expanded_ram (
    input wire MCLK,
    input wire we,
    input wire [9:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:`XDP_EXPANDED_RAM_DEPTH-1];
    // ============================================================
    // synchronous port, no reset so it maps onto block ram
    always @(posedge MCLK) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // xdp_expanded_ram

/* File: rtl/xdp_iram.v */
// 256-byte internal data ram, lower and upper halves
// assumes the controller only enables it for indirect, stack or low direct accesses
`timescale 1ns/100ps
module xdp_iram (
    input wire MCLK,
    input wire we,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:255];
    // ============================================================
    // write on the clock, read straight from the array so data meets the request cycle
    always @(posedge MCLK) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always @* begin
        rdata = mem[addr];
    end
endmodule // xdp_iram

/* File: rtl/xdp_access.v */
// data-memory access logic: dual pointers, aux registers, internal ram vs sfr, expanded_ram vs external bus
// assumes the cpu core issues one request at a time and waits for XDONE; SEC_EXTSEL is a stable strap
`timescale 1ns/100ps
`include "xdp_regs.vh"
module xdp_access (
    input wire MCLK,
    input wire RST_N,
    input wire SEC_EXTSEL,
    input wire IREQ,
    input wire IWR,
    input wire IDIRECT,
    input wire ISTACK,
    input wire [7:0] IADDR,
    input wire [7:0] IWDATA,
    input wire XREQ,
    input wire XWR,
    input wire XUSE_PTR,
    input wire [7:0] XRI_ADDR,
    input wire [7:0] XWDATA,
    input wire PTR_INC,
    input wire [15:0] CODE_ADDR,
    input wire [7:0] P0_IN,
    output reg [7:0] IRDATA,
    output reg IDONE,
    output reg SFR_HIT,
    output reg [7:0] XRDATA,
    output reg XDONE,
    output reg BOOT_SEL,
    output reg [7:0] P0_OUT,
    output reg P0_OE,
    output reg [7:0] P2_OUT,
    output reg P2_OE,
    output reg ALE,
    output reg WR_N,
    output reg RD_N,
    output reg [15:0] PTR_VIEW
);
    // one-hot state codes; the default branch recovers from any illegal code
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_EXPANDED_RAM = 6'h02;
    localparam [5:0] S_ADDR = 6'h04;
    localparam [5:0] S_STRB = 6'h08;
    localparam [5:0] S_HOLD = 6'h10;
    localparam [5:0] S_IRAM = 6'h20;

    reg [15:0] ptr0;
    reg [15:0] ptr1;
    reg psel;
    reg uflag;
    reg boot_en;
    reg extsel;
    reg [1:0] xrs;
    reg stretch;
    reg strap_taken;
    reg [5:0] state;
    reg [4:0] cnt;
    reg [15:0] xaddr;
    reg [7:0] xdata;
    reg xwr_l;
    reg [7:0] p0_s1;
    reg [7:0] p0_s2;
    wire [15:0] cur_ptr;
    wire [15:0] eff_addr;
    wire expanded_ram_hit;
    wire sfr_wr;
    wire [7:0] expanded_ram_rd;
    wire [7:0] iram_rd;
    wire iram_we;
    wire expanded_ram_we;

    // ============================================================
    // helpers
    function [10:0] expanded_ram_limit;
        input [1:0] sel;
        begin
            expanded_ram_limit = {1'b0, sel, 8'hFF} + 11'h001;
        end
    endfunction

    // direct access above the lower half is sfr space; the stack is always ram
    function is_sfr;
        input req;
        input direct;
        input stack;
        input [7:0] addr;
        begin
            is_sfr = req && direct && !stack && (addr > `XDP_LOWER_TOP);
        end
    endfunction

    function [7:0] aux1_read;
        input b_en;
        input u_f;
        input p_s;
        begin
            // bit 2 forced low; reserved bits read zero here
            aux1_read = {2'b00, b_en, 1'b0, u_f, 1'b0, 1'b0, p_s};
        end
    endfunction

    // ============================================================
    // address decode
    assign cur_ptr = psel ? ptr1 : ptr0;
    // register-indirect gives only 8 bits, so it reaches the low 256 bytes
    assign eff_addr = XUSE_PTR ? cur_ptr : {8'h00, XRI_ADDR};
    // smallest size is 256, so register-indirect with external_data_select cleared always hits
    assign expanded_ram_hit = !extsel && ({5'h00, eff_addr[10:0]} == eff_addr)
        && (eff_addr[10:0] < expanded_ram_limit(xrs));
    // direct above 7Fh is sfr space, stack and indirect use ram
    assign sfr_wr = IWR && is_sfr(IREQ, IDIRECT, ISTACK, IADDR);
    assign iram_we = IREQ && IWR && !is_sfr(IREQ, IDIRECT, ISTACK, IADDR);
    assign expanded_ram_we = (state == S_IDLE) && XREQ && XWR && expanded_ram_hit;

    xdp_expanded_ram u_expanded_ram (
        .MCLK(MCLK),
        .we(expanded_ram_we),
        .addr(eff_addr[9:0]),
        .wdata(XWDATA),
        .rdata(expanded_ram_rd)
    );

    xdp_iram u_iram (
        .MCLK(MCLK),
        .we(iram_we),
        .addr(IADDR),
        .wdata(IWDATA),
        .rdata(iram_rd)
    );

    // ============================================================
    // aux registers and pointers
    always @(posedge MCLK) begin
        if (!RST_N) begin
            ptr0 <= 16'h0000;
            ptr1 <= 16'h0000;
            psel <= 1'b0;
            uflag <= 1'b0;
            boot_en <= 1'b0;
            extsel <= 1'b0;
            xrs <= `XDP_XRS_RESET;
            stretch <= 1'b0;
            strap_taken <= 1'b0;
        end else begin
            // a direct sfr write in the strap cycle wins over the strap
            if (!strap_taken) begin
                extsel <= SEC_EXTSEL;
                strap_taken <= 1'b1;
            end
            if (PTR_INC) begin
                if (psel) begin
                    ptr1 <= ptr1 + 16'h0001;
                end else begin
                    ptr0 <= ptr0 + 16'h0001;
                end
            end
            if (sfr_wr) begin
                case (IADDR)
                    `XDP_AUX1_ADDR: begin
                        psel <= IWDATA[`XDP_A1_PSEL];
                        uflag <= IWDATA[`XDP_A1_UFLAG];
                        boot_en <= IWDATA[`XDP_A1_BOOT];
                    end
                    `XDP_AUX0_ADDR: begin
                        extsel <= IWDATA[`XDP_A0_EXTSEL];
                        xrs <= {IWDATA[`XDP_A0_XRS_HI], IWDATA[`XDP_A0_XRS_LO]};
                        stretch <= IWDATA[`XDP_A0_STRETCH];
                    end
                    `XDP_PTR0_LO_ADDR: begin
                        if (psel) begin
                            ptr1[7:0] <= IWDATA;
                        end else begin
                            ptr0[7:0] <= IWDATA;
                        end
                    end
                    `XDP_PTR0_HI_ADDR: begin
                        if (psel) begin
                            ptr1[15:8] <= IWDATA;
                        end else begin
                            ptr0[15:8] <= IWDATA;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ============================================================
    // internal data path: one cycle latency
    always @(posedge MCLK) begin
        if (!RST_N) begin
            IRDATA <= 8'h00;
            IDONE <= 1'b0;
            SFR_HIT <= 1'b0;
            BOOT_SEL <= 1'b0;
            PTR_VIEW <= 16'h0000;
        end else begin
            IDONE <= IREQ;
            SFR_HIT <= is_sfr(IREQ, IDIRECT, ISTACK, IADDR);
            BOOT_SEL <= boot_en && (CODE_ADDR >= `XDP_BOOT_BASE);
            PTR_VIEW <= cur_ptr;
            if (is_sfr(IREQ, IDIRECT, ISTACK, IADDR)) begin
                case (IADDR)
                    `XDP_AUX1_ADDR: begin
                        IRDATA <= aux1_read(boot_en, uflag, psel);
                    end
                    `XDP_AUX0_ADDR: begin
                        IRDATA <= {2'b00, stretch, 1'b0, xrs, extsel, 1'b0};
                    end
                    `XDP_PTR0_LO_ADDR: begin
                        IRDATA <= cur_ptr[7:0];
                    end
                    `XDP_PTR0_HI_ADDR: begin
                        IRDATA <= cur_ptr[15:8];
                    end
                    default: begin
                        IRDATA <= 8'h00;
                    end
                endcase
            end else if (IREQ) begin
                // the ram array reads without a register, so ram data meets IDONE like sfr data
                IRDATA <= iram_rd;
            end
        end
    end

    // ============================================================
    // external data path: expanded_ram or multiplexed bus
    // port 0 pins come from outside the clock domain, so two flops before use
    always @(posedge MCLK) begin
        if (!RST_N) begin
            p0_s1 <= 8'h00;
            p0_s2 <= 8'h00;
        end else begin
            p0_s1 <= P0_IN;
            p0_s2 <= p0_s1;
        end
    end

    // ============================================================
    // bus sequencer
    always @(posedge MCLK) begin
        if (!RST_N) begin
            state <= S_IDLE;
            cnt <= 5'h00;
            xaddr <= 16'h0000;
            xdata <= 8'h00;
            xwr_l <= 1'b0;
            XRDATA <= 8'h00;
            XDONE <= 1'b0;
            P0_OUT <= 8'h00;
            P0_OE <= 1'b0;
            P2_OUT <= 8'h00;
            P2_OE <= 1'b0;
            ALE <= 1'b0;
            WR_N <= 1'b1;
            RD_N <= 1'b1;
        end else begin
            XDONE <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (XREQ) begin
                        xaddr <= eff_addr;
                        xdata <= XWDATA;
                        xwr_l <= XWR;
                        // ram hit: pins are left as they are
                        if (expanded_ram_hit) begin
                            state <= S_EXPANDED_RAM;
                        end else begin
                            state <= S_ADDR;
                            ALE <= 1'b1;
                            P0_OUT <= eff_addr[7:0];
                            P0_OE <= 1'b1;
                            P2_OUT <= eff_addr[15:8];
                            P2_OE <= XUSE_PTR;
                        end
                    end
                end
                S_EXPANDED_RAM: begin
                    XRDATA <= expanded_ram_rd;
                    XDONE <= 1'b1;
                    state <= S_IDLE;
                end
                S_ADDR: begin
                    ALE <= 1'b0;
                    cnt <= stretch ? `XDP_STROBE_LONG : `XDP_STROBE_SHORT;
                    if (xwr_l) begin
                        P0_OUT <= xdata;
                        WR_N <= 1'b0;
                    end else begin
                        P0_OE <= 1'b0;
                        RD_N <= 1'b0;
                    end
                    state <= S_STRB;
                end
                S_STRB: begin
                    // strobe low for exactly cnt clocks
                    // read data is the synced port 0; the two-flop lag fits inside the shortest strobe
                    if (cnt == 5'h01) begin
                        WR_N <= 1'b1;
                        RD_N <= 1'b1;
                        if (!xwr_l) begin
                            XRDATA <= p0_s2;
                        end
                        state <= S_HOLD;
                    end
                    cnt <= cnt - 5'h01;
                end
                S_HOLD: begin
                    // port 2, and port 0 after a write, released one cycle after the strobes so the far side keeps its hold time
                    P0_OE <= 1'b0;
                    P2_OE <= 1'b0;
                    XDONE <= 1'b1;
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // xdp_access

/* File: dv/xdp_ext_mem.sv */
// external memory on the multiplexed port 0 / port 2 bus
// assumes address is valid at ALE and held latched through the strobe
`timescale 1ns/100ps
module xdp_ext_mem (
    input wire MCLK,
    input wire [7:0] P0_OUT,
    input wire P0_OE,
    input wire [7:0] P2_OUT,
    input wire P2_OE,
    input wire ALE,
    input wire WR_N,
    input wire RD_N,
    output wire [7:0] P0_IN
);
    reg [7:0] mem [0:65535];
    reg [15:0] adr = 16'h0000;
    reg [7:0] last = 8'h00;
    // released port 0 toggles every cycle, so stale data cannot pass for a read
    assign P0_IN = P0_OE ? P0_OUT : (!RD_N ? mem[adr] : ~last);
    always @(posedge MCLK) begin
        last <= P0_IN;
        if (ALE)
            adr <= {P2_OE ? P2_OUT : 8'h00, P0_OUT};
        if (!WR_N)
            mem[adr] <= P0_OUT;
    end
endmodule // xdp_ext_mem

/* File: dv/xdp_access_chk.sv */
// checker for xdp_access: bus timing, routing and control bits
// assumes a bind onto xdp_access; sees its ports only
`timescale 1ns/100ps
module xdp_access_chk (
    input wire MCLK,
    input wire RST_N,
    input wire SEC_EXTSEL,
    input wire IREQ,
    input wire IWR,
    input wire IDIRECT,
    input wire ISTACK,
    input wire [7:0] IADDR,
    input wire [7:0] IWDATA,
    input wire XREQ,
    input wire XUSE_PTR,
    input wire [7:0] XRI_ADDR,
    input wire [15:0] CODE_ADDR,
    input wire [7:0] P0_OUT,
    input wire P0_OE,
    input wire [7:0] P2_OUT,
    input wire P2_OE,
    input wire ALE,
    input wire WR_N,
    input wire RD_N,
    input wire IDONE,
    input wire SFR_HIT,
    input wire BOOT_SEL,
    input wire [15:0] PTR_VIEW
);
    // ========
    // shadow control bits, decoded from sfr writes; ext also takes SEC_EXTSEL in the first cycle after reset
    reg boot, ext, str, in_rst;
    reg [4:0] low;
    wire sw = RST_N && IREQ && IWR && IDIRECT && !ISTACK;
    wire bh = boot && CODE_ADDR >= 16'hF800;
    always @(posedge MCLK) begin
        in_rst <= !RST_N;
        low <= (WR_N && RD_N) ? 5'h00 : low + 5'h01;
        if (!RST_N)
            {boot, str} <= 2'b00;
        if (RST_N && in_rst)
            ext <= SEC_EXTSEL;
        if (sw && IADDR == 8'hA2)
            boot <= IWDATA[5];
        if (sw && IADDR == 8'h8E)
            {str, ext} <= {IWDATA[5], IWDATA[1]};
    end
    // ========
    // assertions
    a_strobe_width: assert property (@(posedge MCLK) disable iff (!RST_N)
        $rose(WR_N && RD_N) |-> low == (str ? 5'h1E : 5'h06)) else $error("strobe width wrong");
    a_strobe_excl: assert property (@(posedge MCLK) disable iff (!RST_N)
        WR_N || RD_N) else $error("both strobes low");
    a_ale_strobe: assert property (@(posedge MCLK) disable iff (!RST_N)
        ALE |=> !ALE && !(WR_N && RD_N)) else $error("no strobe after address phase");
    a_ptr_bus: assert property (@(posedge MCLK) disable iff (!RST_N)
        ALE && P2_OE |-> P0_OE && {P2_OUT, P0_OUT} == PTR_VIEW) else $error("pointer address wrong");
    a_ri_addr: assert property (@(posedge MCLK) disable iff (!RST_N)
        XREQ && ext && !XUSE_PTR |=> ALE && P0_OE && !P2_OE && P0_OUT == $past(XRI_ADDR))
        else $error("8-bit address phase wrong");
    a_expanded_ram_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
        XREQ && !ext && !XUSE_PTR |=> (!ALE && WR_N && RD_N) [*3]) else $error("bus moved on ram hit");
    a_sfr_route: assert property (@(posedge MCLK) disable iff (!RST_N)
        IREQ && IDIRECT && !ISTACK && IADDR > 8'h7F |=> IDONE && SFR_HIT) else $error("direct high not sfr");
    a_ind_ram: assert property (@(posedge MCLK) disable iff (!RST_N)
        IREQ && (!IDIRECT || ISTACK) |=> IDONE && !SFR_HIT) else $error("indirect went to sfr");
    a_boot_map: assert property (@(posedge MCLK) disable iff (!RST_N)
        BOOT_SEL == $past(bh)) else $error("boot map select wrong");
endmodule // xdp_access_chk

/* File: dv/xdp_access_tb.sv */
// self-checking bench for xdp_access with an external bus memory
// assumes the partner model and checker files are compiled first
`timescale 1ns/100ps
module xdp_access_tb;
    reg MCLK = 1'b0;
    reg RST_N = 1'b0;
    reg SEC_EXTSEL = 1'b0;
    reg IREQ, IWR, IDIRECT, ISTACK, XREQ, XWR, XUSE_PTR, PTR_INC;
    reg [7:0] IADDR, IWDATA, XRI_ADDR, XWDATA;
    reg [15:0] CODE_ADDR;
    wire [7:0] P0_IN, IRDATA, XRDATA, P0_OUT, P2_OUT;
    wire IDONE, SFR_HIT, XDONE, BOOT_SEL, P0_OE, P2_OE, ALE, WR_N, RD_N;
    wire [15:0] PTR_VIEW;
    integer failures = 0;
    integer comparisons = 0;
    integer bus_cyc = 0;
    initial {IREQ, IWR, IDIRECT, ISTACK, XREQ, XWR, XUSE_PTR, PTR_INC, IADDR, IWDATA, XRI_ADDR, XWDATA, CODE_ADDR} = 56'h0;
    always #25 MCLK = ~MCLK;
    always @(posedge MCLK)
        if (ALE === 1'b1)
            bus_cyc <= bus_cyc + 1;
    xdp_access i_xdp_access (.MCLK, .RST_N, .SEC_EXTSEL, .IREQ, .IWR, .IDIRECT, .ISTACK, .IADDR, .IWDATA,
        .XREQ, .XWR, .XUSE_PTR, .XRI_ADDR, .XWDATA, .PTR_INC, .CODE_ADDR, .P0_IN, .IRDATA, .IDONE, .SFR_HIT,
        .XRDATA, .XDONE, .BOOT_SEL, .P0_OUT, .P0_OE, .P2_OUT, .P2_OE, .ALE, .WR_N, .RD_N, .PTR_VIEW);
    xdp_ext_mem i_xdp_ext_mem (.MCLK, .P0_OUT, .P0_OE, .P2_OUT, .P2_OE, .ALE, .WR_N, .RD_N, .P0_IN);
    // ========
    // tasks
    task check(input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task reset(input s);
        begin
            @(posedge MCLK);
            {RST_N, SEC_EXTSEL} <= {1'b0, s};
            repeat (6) @(posedge MCLK);
            RST_N <= 1'b1;
            repeat (2) @(posedge MCLK);
        end
    endtask
    // answer flags stand one cycle, so they are read at the first falling edge
    task iacc(input w, input d, input s, input [7:0] a, input [7:0] v);
        begin
            @(posedge MCLK);
            {IREQ, IWR, IDIRECT, ISTACK, IADDR, IWDATA} <= {1'b1, w, d, s, a, v};
            @(posedge MCLK);
            IREQ <= 1'b0;
            @(negedge MCLK);
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        iacc(1'b1, 1'b1, 1'b0, a, v);
    endtask
    task xt(input w, input p, input [7:0] a, input [7:0] v, input [15:0] b);
        integer n;
        begin
            @(posedge MCLK);
            {XREQ, XWR, XUSE_PTR, XRI_ADDR, XWDATA} <= {1'b1, w, p, a, v};
            @(posedge MCLK);
            XREQ <= 1'b0;
            @(negedge MCLK);
            for (n = 0; n < 100 && XDONE !== 1'b1; n = n + 1)
                @(negedge MCLK);
            check(XDONE, 1'b1);
            if (!w)
                check(XRDATA, v);
            check(bus_cyc[15:0], b);
        end
    endtask
    task code(input [15:0] a, input e);
        begin
            @(posedge MCLK);
            CODE_ADDR <= a;
            repeat (2) @(negedge MCLK);
            check(BOOT_SEL, e);
        end
    endtask
    // ========
    // tests
    initial begin
        reset(1'b0);
        wr(8'hA2, 8'h2D);
        iacc(1'b0, 1'b1, 1'b0, 8'hA2, 8'h00);
        check(IRDATA, 8'h29);
        check(SFR_HIT, 1'b1);
        wr(8'h83, 8'h12);
        wr(8'h82, 8'h34);
        wr(8'hA2, 8'h28);
        wr(8'h83, 8'h03);
        wr(8'h82, 8'hF0);
        @(negedge MCLK);
        check(PTR_VIEW, 16'h03F0);
        wr(8'hA2, 8'h29);
        @(posedge MCLK);
        PTR_INC <= 1'b1;
        @(posedge MCLK);
        PTR_INC <= 1'b0;
        repeat (2) @(negedge MCLK);
        check(PTR_VIEW, 16'h1235);
        code(16'hF800, 1'b1);
        code(16'hF7FF, 1'b0);
        wr(8'hA2, 8'h08);
        code(16'hFFFF, 1'b0);
        check(PTR_VIEW, 16'h03F0);
        iacc(1'b1, 1'b0, 1'b0, 8'h80, 8'h55);
        check(SFR_HIT, 1'b0);
        iacc(1'b1, 1'b1, 1'b1, 8'hF0, 8'h66);
        check(SFR_HIT, 1'b0);
        iacc(1'b1, 1'b1, 1'b0, 8'h7F, 8'h11);
        check(SFR_HIT, 1'b0);
        wr(8'h80, 8'hAA);
        iacc(1'b0, 1'b0, 1'b0, 8'h80, 8'h00);
        check(IRDATA, 8'h55);
        iacc(1'b0, 1'b0, 1'b0, 8'hF0, 8'h00);
        check(IRDATA, 8'h66);
        iacc(1'b0, 1'b1, 1'b0, 8'h7F, 8'h00);
        check(IRDATA, 8'h11);
        wr(8'h8E, 8'h0C);
        xt(1'b1, 1'b0, 8'hA0, 8'h5A, 16'h0000);
        xt(1'b0, 1'b0, 8'hA0, 8'h5A, 16'h0000);
        xt(1'b1, 1'b1, 8'h00, 8'hC3, 16'h0000);
        xt(1'b0, 1'b1, 8'h00, 8'hC3, 16'h0000);
        // smallest size: the same pointer now falls through to the bus
        wr(8'h8E, 8'h00);
        xt(1'b1, 1'b1, 8'h00, 8'h77, 16'h0001);
        xt(1'b0, 1'b1, 8'h00, 8'h77, 16'h0002);
        wr(8'h8E, 8'h02);
        xt(1'b1, 1'b0, 8'h10, 8'h44, 16'h0003);
        xt(1'b0, 1'b0, 8'h10, 8'h44, 16'h0004);
        wr(8'hA2, 8'h01);
        xt(1'b1, 1'b1, 8'h00, 8'h9C, 16'h0005);
        wr(8'h8E, 8'h22);
        xt(1'b0, 1'b1, 8'h00, 8'h9C, 16'h0006);
        reset(1'b1);
        xt(1'b0, 1'b0, 8'h10, 8'h44, 16'h0007);
        wrap_up;
    end
    // the tests need well under 2000 cycles
    initial begin
        #1000000;
        failures = failures + 1;
        wrap_up;
    end
endmodule // xdp_access_tb
bind xdp_access xdp_access_chk i_xdp_access_chk (.MCLK, .RST_N, .SEC_EXTSEL, .IREQ, .IWR, .IDIRECT, .ISTACK,
    .IADDR, .IWDATA, .XREQ, .XUSE_PTR, .XRI_ADDR, .CODE_ADDR, .P0_OUT, .P0_OE, .P2_OUT, .P2_OE, .ALE, .WR_N,
    .RD_N, .IDONE, .SFR_HIT, .BOOT_SEL, .PTR_VIEW);
